// ---- src/adc_pwr_pkg.sv ----
package adc_pwr_pkg;

   // power-up time in ns and its count on the 100 MHz system clock
   localparam int POWER_UP_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int POWER_UP_CYCLES = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWER_CNT_W = 8;

   // falling serial clock edge thresholds counted from chip select falling
   localparam int EDGE_CNT_W = 5;
   localparam logic [4:0] EDGE_PD_MIN = 5'h02;
   localparam logic [4:0] EDGE_KEEP_UP = 5'h0A;
   localparam logic [4:0] EDGE_FRAME_END = 5'h10;

   // mode after supply application, arbitrary choice
   localparam logic RESET_POWERED_DOWN = 1'b0;

   typedef enum logic {MODE_NORMAL, MODE_POWER_DOWN} mode_t;

endpackage

// ---- src/frame_edge_counter.sv ----
// link-side logic: counts falling serial clock edges inside a frame
module frame_edge_counter
   import adc_pwr_pkg::*;
(
   // link
   input wire logic sclk,
   input wire logic cs_n,
   // result
   output logic [adc_pwr_pkg::EDGE_CNT_W-1:0] edge_count,
   output logic first_edge_seen
);
   import adc_pwr_pkg::*;

   logic [EDGE_CNT_W-1:0] bin_count;
   logic [EDGE_CNT_W-1:0] next_bin_count;
   logic [EDGE_CNT_W-1:0] next_edge_count;
   logic rise_seen;

   ////////////////////////////////////////////////////////////////////////
   // cs_n high clears asynchronously: sclk may stop between frames
   // count leaves in gray code so the system clock never samples a torn word while it counts up
   always_comb begin
      next_bin_count = bin_count;
      if (bin_count != {EDGE_CNT_W{1'b1}}) begin
         next_bin_count = bin_count + 1'b1;
      end
      next_edge_count = next_bin_count ^ (next_bin_count >> 1);
   end

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bin_count <= '0;
         edge_count <= '0;
      end else begin
         bin_count <= next_bin_count;
         edge_count <= next_edge_count;
      end
   end

   // track resumes on the first edge of either polarity
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rise_seen <= 1'b0;
      end else begin
         rise_seen <= 1'b1;
      end
   end

   // both terms only rise inside a frame and gray steps never pass zero, so no low pulse
   assign first_edge_seen = rise_seen | (edge_count != '0);
endmodule

// ---- src/adc_power_up_sequencing.sv ----
module adc_power_up_sequencing
   import adc_pwr_pkg::*;
#(
   parameter int POWER_UP_COUNT = adc_pwr_pkg::POWER_UP_CYCLES
)
(
   // system
   input wire logic clk,
   input wire logic rst_n,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   output logic sdata_oe,
   // status
   output logic powered_down,
   output logic powered_up,
   output logic tracking
);
   import adc_pwr_pkg::*;

   // link-domain results
   logic [EDGE_CNT_W-1:0] link_count;
   logic link_first_edge;

   // crossings into the system clock
   logic [2:0] cs_sync;
   logic [2:0] next_cs_sync;
   logic [1:0] edge_sync;
   logic [1:0] next_edge_sync;
   logic [EDGE_CNT_W-1:0] count_s1;
   logic [EDGE_CNT_W-1:0] next_count_s1;
   logic [EDGE_CNT_W-1:0] count_s2;
   logic [EDGE_CNT_W-1:0] next_count_s2;
   logic [EDGE_CNT_W-1:0] count_s3;
   logic [EDGE_CNT_W-1:0] next_count_s3;
   logic [EDGE_CNT_W-1:0] count_bin;
   logic [EDGE_CNT_W-1:0] older_bin;

   // frame events on the system clock
   logic cs_low;
   logic cs_fall;
   logic cs_rise;
   logic first_edge;
   logic burst_done;
   logic end_keep_up;
   logic end_power_down;
   logic end_glitch;
   logic back_to_sleep;

   // state
   logic [EDGE_CNT_W-1:0] last_count;
   logic [EDGE_CNT_W-1:0] next_last_count;
   mode_t mode;
   mode_t next_mode;
   logic [POWER_CNT_W-1:0] pwr_cnt;
   logic [POWER_CNT_W-1:0] next_pwr_cnt;
   logic track;
   logic next_track;
   logic oe;
   logic next_oe;

   frame_edge_counter u_counter (
      .sclk(sclk),
      .cs_n(cs_n),
      .edge_count(link_count),
      .first_edge_seen(link_first_edge)
   );

   ////////////////////////////////////////////////////////////////////////
   // crossings: count arrives in gray code, three stages deep like cs_n
   always_comb begin
      next_cs_sync = {cs_sync[1:0], cs_n};
      next_edge_sync = {edge_sync[0], link_first_edge};
      next_count_s1 = link_count;
      next_count_s2 = count_s1;
      next_count_s3 = count_s2;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_sync <= 3'h7;
         edge_sync <= 2'h0;
         count_s1 <= '0;
         count_s2 <= '0;
         count_s3 <= '0;
      end else begin
         cs_sync <= next_cs_sync;
         edge_sync <= next_edge_sync;
         count_s1 <= next_count_s1;
         count_s2 <= next_count_s2;
         count_s3 <= next_count_s3;
      end
   end

   // gray to binary, one xor chain per bit
   for (genvar i = 0; i < EDGE_CNT_W; i++) begin : g_gray
      assign count_bin[i] = ^count_s2[EDGE_CNT_W-1:i];
      assign older_bin[i] = ^count_s3[EDGE_CNT_W-1:i];
   end

   ////////////////////////////////////////////////////////////////////////
   // frame events
   assign cs_low = ~cs_sync[1];
   assign cs_fall = cs_sync[2] & ~cs_sync[1];
   assign cs_rise = ~cs_sync[2] & cs_sync[1];
   assign first_edge = edge_sync[1];
   assign burst_done = cs_low && (count_bin >= EDGE_FRAME_END);
   assign end_keep_up = cs_rise && (last_count >= EDGE_KEEP_UP);
   assign end_power_down = cs_rise && (last_count >= EDGE_PD_MIN) && (last_count < EDGE_KEEP_UP);
   assign end_glitch = cs_rise && (last_count < EDGE_PD_MIN);
   assign back_to_sleep = end_power_down || (end_glitch && mode == MODE_POWER_DOWN);

   ////////////////////////////////////////////////////////////////////////
   // edge count of the frame
   // older sample is taken one clock before a low cs_n sample, so the
   // asynchronous clear at cs_n rising never reaches it
   always_comb begin
      next_last_count = last_count;
      if (cs_low) begin
         next_last_count = older_bin;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_count <= '0;
      end else begin
         last_count <= next_last_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode, decided only at the end of a frame
   always_comb begin
      next_mode = mode;
      if (end_keep_up) begin
         next_mode = MODE_NORMAL;
      end else if (end_power_down) begin
         next_mode = MODE_POWER_DOWN;
      end
   end

   // supply start: either mode, chosen by a package constant
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= RESET_POWERED_DOWN ? MODE_POWER_DOWN : MODE_NORMAL;
      end else begin
         mode <= next_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power-up timer
   // asleep it only runs inside a frame; awake it runs to the end, as the
   // converter keeps powering up once cs_n passed edge ten
   always_comb begin
      next_pwr_cnt = pwr_cnt;
      if (back_to_sleep) begin
         next_pwr_cnt = POWER_CNT_W'(POWER_UP_COUNT);
      end else if (pwr_cnt != '0 && (cs_low || mode == MODE_NORMAL)) begin
         next_pwr_cnt = pwr_cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_cnt <= POWER_CNT_W'(POWER_UP_COUNT);
      end else begin
         pwr_cnt <= next_pwr_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // track-and-hold
   always_comb begin
      next_track = track;
      if (cs_low && mode == MODE_POWER_DOWN && first_edge) begin
         next_track = 1'b1;
      end
      if (end_keep_up) begin
         next_track = 1'b1;
      end else if (back_to_sleep) begin
         next_track = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         track <= 1'b1;
      end else begin
         track <= next_track;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output enable: on at cs_n falling, off after the last bit or at cs_n rising
   always_comb begin
      next_oe = oe;
      if (cs_fall) begin
         next_oe = 1'b1;
      end
      if (burst_done || cs_rise) begin
         next_oe = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oe <= 1'b0;
      end else begin
         oe <= next_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status
   assign sdata_oe = oe;
   assign powered_down = (mode == MODE_POWER_DOWN);
   assign powered_up = (mode == MODE_NORMAL) && (pwr_cnt == '0);
   assign tracking = track;
endmodule

// ---- dv/adc_pwr_monitor.sv ----
module adc_pwr_monitor #(
   parameter int POWER_UP_COUNT = 100
)
(
   // system
   input wire logic clk,
   input wire logic rst_n,
   // link and status
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdata_oe,
   input wire logic powered_down,
   input wire logic powered_up,
   input wire logic tracking
);
   timeunit 1ns;
   timeprecision 1ps;
   // longest wait for the power-up timer, in system clocks
   localparam int UP_LIMIT = POWER_UP_COUNT;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence cs_idle; cs_n [*6]; endsequence
   sequence cs_busy; !cs_n [*6]; endsequence
   ////////////////////////////////////////////////////////////
   reset_state_a: assert property ($rose(rst_n) |-> tracking && !powered_down) else $error("bad reset state");
   track_rise_a: assert property ($rose(tracking) |-> !cs_n) else $error("track outside frame");
   up_after_supply_a: assert property ($rose(rst_n) && !powered_down |-> ##[0:UP_LIMIT] (powered_up || powered_down))
      else $error("no power-up after supply");
   down_entry_a: assert property ($rose(powered_down) |-> cs_n ##[0:3] !tracking) else $error("bad entry");
   down_exit_a: assert property ($fell(powered_down) |-> cs_n ##[0:UP_LIMIT] powered_up) else $error("bad exit");
   oe_release_a: assert property (cs_idle |-> !sdata_oe) else $error("output not released");
   mode_hold_a: assert property (cs_busy |-> $stable(powered_down)) else $error("mode moved in frame");
endmodule
bind adc_power_up_sequencing adc_pwr_monitor #(.POWER_UP_COUNT(POWER_UP_COUNT)) mon_u(.clk(clk), .rst_n(rst_n),
   .sclk(sclk), .cs_n(cs_n), .sdata_oe(sdata_oe), .powered_down(powered_down), .powered_up(powered_up),
   .tracking(tracking));

// ---- dv/host_model.sv ----
module host_model (
   // link
   output logic sclk,
   output logic cs_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // clock stands high between frames
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
   end
   // falls counted from chip select low place the rising edge
   task automatic frame(input int falls);
      cs_n = 1'b0;
      #32;
      repeat (falls) begin
         sclk = 1'b0;
         #16;
         sclk = 1'b1;
         #16;
      end
      cs_n = 1'b1;
      // seven periods of quiet keep each frame a whole number of clock periods
      #224;
   endtask
endmodule

// ---- dv/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, cs_n, sdata_oe, powered_down, powered_up, tracking;
   int mismatches = 0;
   int check_count = 0;
   int falls [5] = '{16, 1, 2, 8, 10};
   logic [4:0] exp_pd = 5'h0C;
   logic [4:0] exp_up = 5'h13;
   always #5 clk = ~clk;
   host_model host_u(.sclk(sclk), .cs_n(cs_n));
   adc_power_up_sequencing #(.POWER_UP_COUNT(5)) dut_u(.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .sdata_oe(sdata_oe), .powered_down(powered_down), .powered_up(powered_up), .tracking(tracking));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("tracking", tracking, 1'b1);
      chk("powered_down", powered_down, 1'b0);
      chk("powered_up", powered_up, 1'b0);
      // dummy, glitch, boundary entry, aborted exit, exit at edge ten
      for (int i = 0; i < 5; i++) begin
         fork
            host_u.frame(falls[i]);
            begin
               repeat (6) @(negedge clk);
               chk("sdata_oe", sdata_oe, 1'b1);
               repeat (4) @(negedge clk);
               chk("tracking", tracking, 1'b1);
            end
         join
         @(negedge clk);
         chk("powered_down", powered_down, exp_pd[i]);
         chk("powered_up", powered_up, exp_up[i]);
         chk("tracking", tracking, exp_up[i]);
         chk("sdata_oe", sdata_oe, 1'b0);
         $display("test %0d done, %0d falls", i, falls[i]);
      end
      close_out();
   end
   initial begin
      #50us;
      mismatches++;
      close_out();
   end
endmodule
